// ===== core/wssd_pkg.sv
// package for the steering, shutdown and rising dead-band block
// assumes an axi4-lite master with 32-bit data and one clock domain
package wssd_pkg;
	// register byte addresses
	localparam logic [3:0] WSSD_STR_ADDR = 4'h0; // output steering control
	localparam logic [3:0] WSSD_AS0_ADDR = 4'h4; // shutdown control and status
	localparam logic [3:0] WSSD_AS1_ADDR = 4'h8; // shutdown source enables
	localparam logic [3:0] WSSD_DBR_ADDR = 4'hc; // rising dead-band count
	// field positions
	localparam int WSSD_SHUT_BIT = 7;
	localparam int WSSD_REN_BIT  = 6;
	// reset values
	localparam logic [7:0] WSSD_STR_RST = 8'h00;
	localparam logic [7:0] WSSD_AS0_RST = 8'h14; // both level fields 01
	localparam logic [4:0] WSSD_AS1_RST = 5'h00;
	localparam logic [5:0] WSSD_DBR_RST = 6'h00;
	// shutdown level codes
	localparam logic [1:0] WSSD_LVL_HIGH = 2'h3;
	localparam logic [1:0] WSSD_LVL_LOW  = 2'h2;
	localparam logic [1:0] WSSD_LVL_HIZ  = 2'h1;
	localparam logic [1:0] WSSD_LVL_IDLE = 2'h0;
	// mode codes
	localparam logic [2:0] WSSD_MODE_ASYNC = 3'h0;
	localparam logic [2:0] WSSD_MODE_SYNC  = 3'h1;
	// axi responses
	localparam logic [1:0] WSSD_RESP_OKAY   = 2'h0;
	localparam logic [1:0] WSSD_RESP_SLVERR = 2'h2;

	// shutdown request sources
	typedef struct packed {
		logic logic_cell_four_output;
		logic logic_cell_two_output;
		logic comparator_two_result;
		logic comparator_one_result;
		logic pin_selected_shutdown_input;
	} wssd_src_t;

	// generator core settings from outside the block
	typedef struct packed {
		logic       enable;
		logic [2:0] mode;
		logic [3:0] invert; // d c b a
	} wssd_core_t;
endpackage

// ===== core/wssd_top.sv
// steering, auto-shutdown and rising dead-band logic of a waveform generator
// assumes core settings and sources are synchronous to aclk, the generator clock
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module wssd_top
	import wssd_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [3:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [3:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire wssd_pkg::wssd_core_t core_cfg,
	input  wire logic              data_in,
	input  wire wssd_pkg::wssd_src_t shutdown_src,
	output logic [3:0]             wave_out,
	output logic [3:0]             wave_out_en
);
	import wssd_pkg::*;

	logic [7:0] str_ff;        // overrides high nibble, steer enables low
	logic [3:0] steer_act_ff;  // active steer enables
	logic       shut_ff;       // shutdown status flag
	logic       ren_ff;        // auto-restart enable
	logic [1:0] lvl_bd_ff;     // level code for b and d
	logic [1:0] lvl_ac_ff;     // level code for a and c
	logic [4:0] src_en_ff;     // source enables
	logic [5:0] dbr_ff;        // rising dead-band count
	logic       hold_ff;       // outputs held until data rises
	logic       data_d_ff;     // data input delayed one cycle
	logic [5:0] db_cnt_ff;     // dead-band countdown
	logic       data_db_ff;    // data after rising dead-band
	logic       idle_ok_ff;    // dead-band elapsed since shutdown
	logic [5:0] idle_cnt_ff;   // idle dead-band countdown
	logic [3:0] nxt_wave;      // next output values
	logic [3:0] nxt_wave_en;   // next output enables
	logic       aw_got_ff;     // write address taken
	logic       w_got_ff;      // write data taken
	logic [3:0] aw_ff;         // held write address
	logic [31:0] wd_ff;        // held write data
	logic       data_rise;     // rising edge of data input
	logic       src_hit;       // an enabled source requests shutdown
	logic       steer_mode;    // mode is 00x
	logic       wr_go;         // write performed this cycle
	logic       shut_wr;       // software writes the shutdown register
	logic       in_shut;       // outputs in shutdown state

	// level code to pin drive and enable, idle uses polarity
	function automatic logic [1:0] lvl_drive(input logic [1:0] code, input logic inv,
		input logic ok);
		case (code)
			WSSD_LVL_HIGH: lvl_drive = 2'b11;
			WSSD_LVL_LOW:  lvl_drive = 2'b01;
			WSSD_LVL_HIZ:  lvl_drive = 2'b00;
			default:       lvl_drive = {inv, ok};
		endcase
	endfunction

	assign data_rise  = data_in & ~data_d_ff;
	assign src_hit    = |(src_en_ff & shutdown_src);
	assign steer_mode = (core_cfg.mode[2:1] == 2'b00);
	assign wr_go      = aw_got_ff & w_got_ff & ~s_axi_bvalid;
	assign shut_wr    = wr_go & (aw_ff == WSSD_AS0_ADDR);
	assign in_shut    = shut_ff | hold_ff;

	// write address and data channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			aw_ff     <= 4'h0;
			wd_ff     <= 32'h0;
		end else if (wr_go) begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff <= 1'b1;
				aw_ff     <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff <= 1'b1;
				wd_ff    <= s_axi_wdata & {{24{1'b0}}, {8{s_axi_wstrb[0]}}};
			end
		end
	end

	// ready flops mirror what is still missing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= ~s_axi_awready & ~aw_got_ff & ~s_axi_bvalid & s_axi_awvalid;
			s_axi_wready  <= ~s_axi_wready & ~w_got_ff & ~s_axi_bvalid & s_axi_wvalid;
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= WSSD_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (aw_ff == WSSD_STR_ADDR || aw_ff == WSSD_AS0_ADDR ||
				aw_ff == WSSD_AS1_ADDR || aw_ff == WSSD_DBR_ADDR) begin
				s_axi_bresp <= WSSD_RESP_OKAY;
			end else begin
				s_axi_bresp <= WSSD_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			str_ff    <= WSSD_STR_RST;
			ren_ff    <= WSSD_AS0_RST[WSSD_REN_BIT];
			lvl_bd_ff <= WSSD_AS0_RST[5:4];
			lvl_ac_ff <= WSSD_AS0_RST[3:2];
			src_en_ff <= WSSD_AS1_RST;
			dbr_ff    <= WSSD_DBR_RST;
		end else if (wr_go) begin
			if (aw_ff == WSSD_STR_ADDR) begin
				str_ff <= wd_ff[7:0];
			end else if (aw_ff == WSSD_AS0_ADDR) begin
				ren_ff    <= wd_ff[WSSD_REN_BIT];
				lvl_bd_ff <= wd_ff[5:4];
				lvl_ac_ff <= wd_ff[3:2];
			end else if (aw_ff == WSSD_AS1_ADDR) begin
				src_en_ff <= wd_ff[4:0];
			end else if (aw_ff == WSSD_DBR_ADDR) begin
				dbr_ff <= wd_ff[5:0];
			end
		end
	end

	// active steer enables: direct in async mode, on data rise in sync mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			steer_act_ff <= WSSD_STR_RST[3:0];
		end else if (core_cfg.mode != WSSD_MODE_SYNC) begin
			steer_act_ff <= str_ff[3:0];
		end else if (data_rise) begin
			steer_act_ff <= str_ff[3:0];
		end
	end

	// shutdown flag: sources set it, set wins over any clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shut_ff <= 1'b0;
		end else if (src_hit) begin
			shut_ff <= 1'b1;
		end else if (shut_wr && !core_cfg.enable && wd_ff[WSSD_SHUT_BIT]) begin
			shut_ff <= 1'b1;
		end else if (shut_wr && !wd_ff[WSSD_SHUT_BIT]) begin
			shut_ff <= 1'b0;
		end else if (ren_ff) begin
			shut_ff <= 1'b0;
		end
	end

	// hold after the flag clears until the data input rises
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_ff <= 1'b0;
		end else if (shut_ff) begin
			hold_ff <= 1'b1;
		end else if (data_rise) begin
			hold_ff <= 1'b0;
		end
	end

	// rising dead-band: delay rising edge dbr_ff cycles, falls pass
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_d_ff  <= 1'b0;
			db_cnt_ff  <= 6'h00;
			data_db_ff <= 1'b0;
		end else begin
			data_d_ff <= data_in;
			if (!data_in) begin
				data_db_ff <= 1'b0;
				db_cnt_ff  <= 6'h00;
			end else if (dbr_ff == 6'h00) begin
				data_db_ff <= 1'b1;
			end else if (data_rise) begin
				db_cnt_ff <= dbr_ff;
			end else if (db_cnt_ff > 6'h01) begin
				db_cnt_ff <= db_cnt_ff - 6'h01;
			end else begin
				data_db_ff <= 1'b1;
			end
		end
	end

	// idle level waits one dead-band interval after shutdown starts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_cnt_ff <= 6'h00;
			idle_ok_ff  <= 1'b0;
		end else if (!in_shut) begin
			idle_cnt_ff <= dbr_ff;
			idle_ok_ff  <= 1'b0;
		end else if (idle_cnt_ff != 6'h00) begin
			idle_cnt_ff <= idle_cnt_ff - 6'h01;
		end else begin
			idle_ok_ff <= 1'b1;
		end
	end

	// next output drive per pin
	always_comb begin
		logic [1:0] d;
		d = 2'b00;
		nxt_wave    = 4'h0;
		nxt_wave_en = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (in_shut) begin
				d = lvl_drive(i[0] ? lvl_bd_ff : lvl_ac_ff, core_cfg.invert[i], idle_ok_ff);
				nxt_wave[i]    = d[1];
				nxt_wave_en[i] = d[0];
			end else if (!steer_mode || !core_cfg.enable) begin
				nxt_wave[i]    = core_cfg.invert[i];
				nxt_wave_en[i] = 1'b1;
			end else if (steer_act_ff[i]) begin
				nxt_wave[i]    = data_db_ff ^ core_cfg.invert[i];
				nxt_wave_en[i] = 1'b1;
			end else begin
				nxt_wave[i]    = str_ff[4 + i];
				nxt_wave_en[i] = 1'b1;
			end
		end
	end

	// registered pin outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wave_out    <= 4'h0;
			wave_out_en <= 4'h0;
		end else begin
			wave_out    <= nxt_wave;
			wave_out_en <= nxt_wave_en;
		end
	end

	// read channel, one cycle answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= WSSD_RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else if (s_axi_arready) begin
			s_axi_arready <= 1'b0;
		end else if (s_axi_arvalid) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= WSSD_RESP_OKAY;
			if (s_axi_araddr == WSSD_STR_ADDR) begin
				s_axi_rdata <= {24'h0, str_ff};
			end else if (s_axi_araddr == WSSD_AS0_ADDR) begin
				s_axi_rdata <= {24'h0, shut_ff, ren_ff, lvl_bd_ff, lvl_ac_ff, 2'b00};
			end else if (s_axi_araddr == WSSD_AS1_ADDR) begin
				s_axi_rdata <= {27'h0, src_en_ff};
			end else if (s_axi_araddr == WSSD_DBR_ADDR) begin
				s_axi_rdata <= {26'h0, dbr_ff};
			end else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= WSSD_RESP_SLVERR;
			end
		end
	end

	// enabled source raises the flag next edge
	a_source_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		src_hit |=> shut_ff) else $error("enabled source did not set shutdown");
	// flag stays at least until the source drops
	a_flag_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		shut_ff && src_hit |=> shut_ff) else $error("shutdown flag fell early");
	// auto restart clears flag once quiet
	a_restart_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		shut_ff && ren_ff && !src_hit && !wr_go |=> !shut_ff) else $error("no auto restart");
	// hold persists until data rises
	sequence s_held;
		!shut_ff && hold_ff && !data_rise;
	endsequence
	a_hold_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		s_held |=> hold_ff) else $error("hold ended without data rise");
	// hi-z code releases a/c pins
	a_hiz_ac: assert property (@(posedge aclk) disable iff (!aresetn)
		in_shut && lvl_ac_ff == WSSD_LVL_HIZ |=> !wave_out_en[0] && !wave_out_en[2])
		else $error("a/c not released");
	// high code drives b/d high
	a_high_bd: assert property (@(posedge aclk) disable iff (!aresetn)
		in_shut && lvl_bd_ff == WSSD_LVL_HIGH |=> wave_out[1] && wave_out[3])
		else $error("b/d not high");
	// override drives pin a when not steering
	a_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!in_shut && steer_mode && core_cfg.enable && !steer_act_ff[0]
		|=> wave_out[0] == $past(str_ff[4])) else $error("override a wrong");
	// zero count passes data with no delay
	a_bypass_db: assert property (@(posedge aclk) disable iff (!aresetn)
		dbr_ff == 6'h00 && data_in |=> data_db_ff) else $error("dead-band not bypassed");
	// nonzero count delays the rise
	a_delay_db: assert property (@(posedge aclk) disable iff (!aresetn)
		dbr_ff != 6'h00 && data_rise |=> !data_db_ff) else $error("rise not delayed");
	// bits 31:8 of every read answer are zero
	a_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("high bits nonzero");
	// software may raise the flag while the generator is disabled
	a_write_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		shut_wr && !core_cfg.enable && wd_ff[WSSD_SHUT_BIT] |=> shut_ff)
		else $error("flag write ignored while disabled");
	// low code drives a/c to zero
	a_low_ac: assert property (@(posedge aclk) disable iff (!aresetn)
		in_shut && lvl_ac_ff == WSSD_LVL_LOW
		|=> !wave_out[0] && !wave_out[2] && wave_out_en[0] && wave_out_en[2])
		else $error("a/c not driven low");
	// steered pin a follows dead-banded data with its polarity
	a_steer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!in_shut && steer_mode && core_cfg.enable && steer_act_ff[0]
		|=> wave_out[0] == ($past(data_db_ff) ^ $past(core_cfg.invert[0])))
		else $error("steered a wrong");
	// sync mode keeps active enables until the data rises
	a_sync_buffer: assert property (@(posedge aclk) disable iff (!aresetn)
		core_cfg.mode == WSSD_MODE_SYNC && !data_rise |=> $stable(steer_act_ff))
		else $error("steer enables changed without data rise");
	// idle code: b/d stay released until the dead-band has run out
	sequence s_idle_wait;
		in_shut && lvl_bd_ff == WSSD_LVL_IDLE && !idle_ok_ff;
	endsequence
	a_idle_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		s_idle_wait |=> !wave_out_en[1] && !wave_out_en[3])
		else $error("b/d idle driven before dead-band");
endmodule

// ===== testbench/wssd_gate_drv.sv
// gate driver model for the four generator pins
// assumes a pin floats whenever its drive enable is low
`timescale 1ns/10ps
module wssd_gate_drv (
	input  wire logic       aclk,
	input  wire logic [3:0] wave_out,
	input  wire logic [3:0] wave_out_en,
	output logic [3:0]      gate_in
);
	logic [3:0] last_ff = 4'h0; // last driven level
	// a floating pin shows the inverse of its last level
	always_comb begin
		gate_in = (wave_out & wave_out_en) | (~last_ff & ~wave_out_en);
	end
	// remember the last driven level only, so a floating pin holds steady
	always_ff @(posedge aclk) begin
		last_ff <= (wave_out & wave_out_en) | (last_ff & ~wave_out_en);
	end
endmodule

// ===== testbench/wssd_top_tb.sv
// bench for the steering, shutdown and rising dead-band block
// assumes the package and the gate driver model are compiled first
`timescale 1ns/10ps
module wssd_top_tb;
	import wssd_pkg::*;
	logic        aclk = 1'b0;    // 40 mhz clock
	logic        aresetn = 1'b0; // reset, active low
	logic [3:0]  awaddr = 4'h0;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;   // full word lanes
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [3:0]  araddr = 4'h0;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	wssd_core_t  core_cfg = '0;  // enable, mode, invert
	logic        data_in = 1'b0; // waveform in
	wssd_src_t   src = '0;       // shutdown requests
	logic [3:0]  wave_out;
	logic [3:0]  wave_out_en;
	logic [3:0]  pins;           // levels at the gate driver
	int          bad_count = 0;
	int          comparisons = 0;
	int          c0;
	int          c3;
	always #12.5 aclk = ~aclk;
	wssd_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .core_cfg(core_cfg), .data_in(data_in),
		.shutdown_src(src), .wave_out(wave_out), .wave_out_en(wave_out_en));
	wssd_gate_drv gate_u (.aclk(aclk), .wave_out(wave_out),
		.wave_out_en(wave_out_en), .gate_in(pins));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// a wait that ran out
	task automatic lost();
		chk(32'h0, 32'h1);
		close_out();
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// pins compared only where driven, then the enables
	task automatic cp(input logic [3:0] p, input logic [3:0] e);
		#1;
		chk({28'h0, pins & e}, {28'h0, p & e});
		chk({28'h0, wave_out_en}, {28'h0, e});
		@(posedge aclk);
	endtask
	task automatic drv(input logic d, input logic [4:0] s, input int n);
		@(posedge aclk);
		data_in <= d;
		src <= s;
		wt(n);
	endtask
	task automatic cfg(input logic e, input logic [2:0] m, input logic [3:0] v);
		@(posedge aclk);
		core_cfg <= '{e, m, v};
	endtask
	// axi4-lite write, address and data offered together
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
			if (n > 50) lost();
		end while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, WSSD_RESP_OKAY});
	endtask
	// axi4-lite read with expected byte and response
	task automatic rd(input logic [3:0] a, input logic [7:0] e,
		input logic [1:0] r = WSSD_RESP_OKAY);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			n++;
			if (n > 50) lost();
		end while (!rvalid);
		rready <= 1'b0;
		chk(rdata, {24'h0, e});
		chk({30'h0, rresp}, {30'h0, r});
	endtask
	// cycles from a data rise to the rise of output a
	task automatic meas(output int c);
		drv(1'b0, 5'h0, 4);
		drv(1'b1, 5'h0, 0);
		c = 0;
		while (pins[0] !== 1'b1) begin
			@(posedge aclk);
			#1;
			c++;
			if (c > 100) lost();
		end
	endtask
	// main sequence
	initial begin
		wt(20);
		aresetn <= 1'b1;
		rd(WSSD_STR_ADDR, WSSD_STR_RST);
		rd(WSSD_AS0_ADDR, WSSD_AS0_RST);
		rd(WSSD_AS1_ADDR, {3'h0, WSSD_AS1_RST});
		rd(WSSD_DBR_ADDR, {2'h0, WSSD_DBR_RST});
		rd(4'h2, 8'h00, WSSD_RESP_SLVERR);
		wr(4'h8, 8'hff);
		rd(4'h8, 8'h1f);
		wr(4'hc, 8'hff);
		rd(4'hc, 8'h3f);
		cfg(1'b1, WSSD_MODE_ASYNC, 4'h0);
		wr(4'h4, 8'hbf);
		rd(4'h4, 8'h3c);
		wr(4'h8, 8'h00);
		wr(4'hc, 8'h00);
		drv(1'b1, 5'h0, 2);
		wr(4'h0, 8'ha5);
		drv(1'b1, 5'h0, 4);
		cp(4'hf, 4'hf);
		drv(1'b0, 5'h0, 4);
		cp(4'ha, 4'hf);
		cfg(1'b1, WSSD_MODE_ASYNC, 4'h1);
		wt(3);
		cp(4'hb, 4'hf);
		cfg(1'b1, 3'h2, 4'h6);
		wt(3);
		cp(4'h6, 4'hf);
		cfg(1'b1, WSSD_MODE_ASYNC, 4'h0);
		wr(4'h0, 8'h00);
		drv(1'b1, 5'h0, 4);
		cfg(1'b1, WSSD_MODE_SYNC, 4'h0);
		wr(4'h0, 8'h01);
		wt(6);
		cp(4'h0, 4'hf);
		drv(1'b0, 5'h0, 2);
		drv(1'b1, 5'h0, 4);
		cp(4'h1, 4'hf);
		cfg(1'b1, WSSD_MODE_ASYNC, 4'h0);
		meas(c0);
		wr(4'hc, 8'h03);
		meas(c3);
		chk(32'(c3 - c0 >= 3 && c3 - c0 <= 4), 32'h1);
		chk(32'(c0), 32'h2);
		wr(4'h0, 8'h00);
		wr(4'h4, 8'h38);
		wr(4'h8, 8'h01);
		drv(1'b0, 5'h01, 4);
		cp(4'ha, 4'hf);
		rd(4'h4, 8'hb8);
		drv(1'b0, 5'h0, 4);
		rd(4'h4, 8'hb8);
		wr(4'h4, 8'h38);
		wt(3);
		cp(4'ha, 4'hf);
		drv(1'b1, 5'h0, 4);
		cp(4'h0, 4'hf);
		wr(4'h4, 8'h14);
		drv(1'b0, 5'h01, 4);
		cp(4'h0, 4'h0);
		drv(1'b0, 5'h0, 1);
		wr(4'h4, 8'h14);
		drv(1'b1, 5'h0, 2);
		wr(4'h4, 8'h00);
		cfg(1'b1, WSSD_MODE_ASYNC, 4'h5);
		drv(1'b0, 5'h01, 3);
		cp(4'h0, 4'h0);
		wt(12);
		cp(4'h5, 4'hf);
		drv(1'b0, 5'h0, 1);
		wr(4'h4, 8'h38);
		cfg(1'b0, WSSD_MODE_ASYNC, 4'h0);
		drv(1'b1, 5'h0, 2);
		wr(4'h4, 8'hb8);
		rd(4'h4, 8'hb8);
		wt(2);
		cp(4'ha, 4'hf);
		wr(4'h4, 8'h78);
		cfg(1'b1, WSSD_MODE_ASYNC, 4'h0);
		for (int i = 0; i < 5; i++) begin
			wr(4'h8, 8'h01 << i);
			drv(1'b0, ~(5'h01 << i), 4);
			rd(4'h4, 8'h78);
			drv(1'b0, 5'h01 << i, 4);
			rd(4'h4, 8'hf8);
			drv(1'b0, 5'h0, 4);
			rd(4'h4, 8'h78);
		end
		close_out();
	end
endmodule
